// ### src/rtcs_defines.svh
`ifndef RTCS_DEFINES_SVH
`define RTCS_DEFINES_SVH

// header layout
`define RTCS_HDR_BITS 4'h8
`define RTCS_PREAMBLE 4'h6
`define RTCS_CMD_RESET 3'h0
`define RTCS_CMD_STATUS 3'h1
`define RTCS_CMD_TIME_YEAR 3'h2
`define RTCS_CMD_TIME_HOUR 3'h3
`define RTCS_CMD_ALARM_FREQ 3'h4

// transfer lengths in bits and bytes
`define RTCS_LEN_TIME_YEAR 7'h38
`define RTCS_LEN_TIME_HOUR 7'h18
`define RTCS_LEN_STATUS 7'h08
`define RTCS_LEN_ALARM_FREQ 7'h10
`define RTCS_BYTES_TIME_YEAR 3'h7
`define RTCS_BYTES_TIME_HOUR 3'h3
`define RTCS_BYTES_STATUS 3'h1
`define RTCS_BASE_YEAR 6'h00
`define RTCS_BASE_HOUR 6'h20

// calendar_time field positions (byte order year..second, lsb first)
`define RTCS_HOUR_LSB 32
`define RTCS_MINUTE_LSB 40

// mode_and_flags bit positions
`define RTCS_ST_POWER 7
`define RTCS_ST_H24 6
`define RTCS_ST_ALARM_EN 5
`define RTCS_ST_MINUTE_SEL 3
`define RTCS_ST_FREQ_SEL 1
`define RTCS_ST_WRITABLE 8'h6a

// reset values
`define RTCS_TIME_DEFAULT 56'h00000000010100
`define RTCS_STATUS_POWERUP 8'h82
`define RTCS_ALARM_POWERUP 16'h8000
`define RTCS_STATUS_CLEAR 8'h00
`define RTCS_ALARM_CLEAR 16'h0000

// per-minute timing
`define RTCS_SEC_LAST 6'h3b
`define RTCS_SEC_HALF 6'h1e

`endif

// ### src/rtcs_pkg.sv
package rtcs_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HEAD = 5'h02,
    ST_READ = 5'h04,
    ST_WRITE = 5'h08,
    ST_DONE = 5'h10
  } rtcs_state_e;

  typedef struct packed {
    logic [1:0] used;
    logic rdIdx;
    logic [7:0] ent0;
    logic [7:0] ent1;
  } rtcs_buf_s;

  typedef struct packed {
    rtcs_state_e state;
    logic csQ;
    logic sckQ;
    logic [7:0] hdr;
    logic [3:0] hcnt;
    logic [2:0] cmd;
    logic [6:0] dcnt;
    logic [6:0] dlen;
    logic [5:0] base;
    logic [2:0] loadIdx;
    logic [2:0] nLoad;
    logic [7:0] outByte;
    logic [2:0] obit;
    logic sdaOe;
    logic [55:0] timeReg;
    logic [7:0] status;
    logic [7:0] stShift;
    logic [15:0] alarmReg;
    logic [15:0] divCnt;
    logic [5:0] secCnt;
    logic minArmed;
    logic irqHold;
    logic irqOe;
  } rtcs_state_s;

endpackage

// ### src/rtcs_serial_regs.sv
// Overview of operation
// [R1] host sends fixed preamble 0110 first after raising chip select
// [R2] header is preamble, three-bit command, then one direction bit
// [R3] commands: 000 reset, 001 status, 010 time from year, 011 from hour, 100 alarm
// [R4] reset command loads default calendar, direction bit ignored
// [R5] unknown command codes do nothing
// [R6] host never issues test-mode codes 110 or 111
// [R7] bits presented on falling edge, header taken on eighth rising edge
// [R8] direction 1: device drives read data on following falling edges
// [R9] direction 0: incoming bits stored into selected register
// [R10] fewer than eight clocks: keep waiting, do nothing
// [R11] clocks beyond the needed count are ignored
// [R12] calendar kept as BCD digits in one 56-bit register
// [R13] time moves lsb first, starting at low digit of year
// [R14] status bits 4, 2, 0 drop writes and read zero
// [R15] status bit 7 is sticky read-only supply-drop flag
// [R16] reset command or status read clears the supply-drop flag
// [R17] status bit 6: 0 twelve-hour, 1 twenty-four-hour
// [R18] status bit 5 enables alarm interrupt output
// [R19] status bit 3 picks alarm/frequency or per-minute family
// [R20] status bit 1 picks steady/frequency versus alarm/edge output
// [R21] write-only 16-bit register holds alarm time or frequency taps
// [R22] alarm holds BCD hour with afternoon flag and BCD minute
// [R23] mismatched afternoon flag means alarm never matches
// [R24] each set bit picks a divided clock, all ANDed onto interrupt
// [R25] data line released except while shifting out read bits
// [R26] reset command clears status to 00h and alarm register to 0000h
// [R27] power-up sets status 82h and alarm register 8000h
// [R28] alarm only with enable 1 and both selects 0, held low on match
`timescale 1ns/100ps

module rtcs_pair_buf (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic inValid,
  output logic inReady,
  input wire logic [7:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [7:0] outData
);
  rtcs_pkg::rtcs_buf_s r;
  rtcs_pkg::rtcs_buf_s n;
  logic push;
  logic pop;

  always_comb begin
    inReady = (r.used != 2'h2);
    outValid = (r.used != 2'h0);
    outData = r.rdIdx ? r.ent1 : r.ent0;
    push = inValid && inReady;
    pop = outValid && outReady;
    n = r;
    // write slot sits one past the read slot when one entry is held
    if (push) begin
      if (r.rdIdx ^ r.used[0]) begin
        n.ent1 = inData;
      end else begin
        n.ent0 = inData;
      end
    end
    if (pop) begin
      n.rdIdx = ~r.rdIdx;
    end
    // fill count moves by push minus pop
    n.used = r.used + {1'b0, push} - {1'b0, pop};
    if (clr) begin
      n.used = 2'h0;
      n.rdIdx = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // rtcs_pair_buf

module rtcs_serial_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chipSelect,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic oscTick,
  input wire logic supplyLow,
  output logic irqOut,
  output logic irqOe
);
  `include "rtcs_defines.svh"

  rtcs_pkg::rtcs_state_s r;
  rtcs_pkg::rtcs_state_s n;
  logic sckRise;
  logic sckFall;
  logic csRise;
  logic loadValid;
  logic loadReady;
  logic [7:0] loadByte;
  logic popValid;
  logic popReady;
  logic [7:0] popByte;
  logic [55:0] timeShifted;
  logic [5:0] tbit;
  logic alarmMode;
  logic freqMode;
  logic edgeMode;
  logic steadyMode;
  logic alarmMatch;
  logic freqLevel;
  logic minuteCarry;
  logic stWriteDone;

  // two-entry buffer between the byte loader and the bit shifter
  rtcs_pair_buf u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .clr(r.state != rtcs_pkg::ST_READ),
    .inValid(loadValid),
    .inReady(loadReady),
    .inData(loadByte),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popByte)
  );

  assign serialDataOut = 1'b0;
  assign serialDataOe = r.sdaOe;
  assign irqOut = 1'b0;
  assign irqOe = r.irqOe;

  always_comb begin
    n = r;
    n.csQ = chipSelect;
    n.sckQ = serialClock;
    csRise = chipSelect && !r.csQ;
    sckRise = chipSelect && serialClock && !r.sckQ;
    sckFall = chipSelect && !serialClock && r.sckQ;
    stWriteDone = 1'b0;
    tbit = 6'(r.base + r.dcnt[5:0]);

    // read byte loader feeds the two-entry buffer
    timeShifted = r.timeReg >> {r.base + {r.loadIdx, 3'h0}};
    loadValid = (r.state == rtcs_pkg::ST_READ) && (r.loadIdx < r.nLoad);
    loadByte = (r.cmd == `RTCS_CMD_STATUS) ? r.status : timeShifted[7:0]; // [R13]
    if (loadValid && loadReady) begin
      n.loadIdx = r.loadIdx + 3'h1;
      if (r.cmd == `RTCS_CMD_STATUS) begin
        n.status[`RTCS_ST_POWER] = 1'b0; // [R16]
      end
    end

    // one byte leaves the buffer per eight read bits
    popReady = (r.state == rtcs_pkg::ST_READ) && sckFall && (r.obit == 3'h0)
      && (r.dcnt < r.dlen);

    // frame sequencer: header, then read or write, then wait for deselect
    case (r.state)
      rtcs_pkg::ST_IDLE: begin
        if (csRise || chipSelect) begin
          n.state = rtcs_pkg::ST_HEAD;
          n.hcnt = 4'h0;
        end
      end
      rtcs_pkg::ST_HEAD: begin
        if (sckRise) begin // [R7]
          n.hdr = {r.hdr[6:0], serialDataIn};
          n.hcnt = r.hcnt + 4'h1; // [R10]
          if (r.hcnt + 4'h1 == `RTCS_HDR_BITS) begin
            n.cmd = r.hdr[2:0]; // [R2]
            n.dcnt = 7'h0;
            n.loadIdx = 3'h0;
            n.obit = 3'h0;
            n.state = rtcs_pkg::ST_DONE;
            // a bad preamble or unknown code waits for deselect
            if (r.hdr[6:3] == `RTCS_PREAMBLE) begin // [R1]
              case (r.hdr[2:0]) // [R3]
                `RTCS_CMD_RESET: begin
                  n.timeReg = `RTCS_TIME_DEFAULT; // [R4]
                  n.status = `RTCS_STATUS_CLEAR; // [R26]
                  n.alarmReg = `RTCS_ALARM_CLEAR; // [R26]
                end
                `RTCS_CMD_STATUS: begin
                  n.dlen = `RTCS_LEN_STATUS;
                  n.nLoad = `RTCS_BYTES_STATUS;
                  n.base = `RTCS_BASE_YEAR;
                  n.state = serialDataIn ? rtcs_pkg::ST_READ : rtcs_pkg::ST_WRITE;
                end
                `RTCS_CMD_TIME_YEAR: begin
                  n.dlen = `RTCS_LEN_TIME_YEAR;
                  n.nLoad = `RTCS_BYTES_TIME_YEAR;
                  n.base = `RTCS_BASE_YEAR; // [R13]
                  n.state = serialDataIn ? rtcs_pkg::ST_READ : rtcs_pkg::ST_WRITE;
                end
                `RTCS_CMD_TIME_HOUR: begin
                  n.dlen = `RTCS_LEN_TIME_HOUR;
                  n.nLoad = `RTCS_BYTES_TIME_HOUR;
                  n.base = `RTCS_BASE_HOUR;
                  n.state = serialDataIn ? rtcs_pkg::ST_READ : rtcs_pkg::ST_WRITE;
                end
                `RTCS_CMD_ALARM_FREQ: begin
                  n.dlen = `RTCS_LEN_ALARM_FREQ;
                  n.base = `RTCS_BASE_YEAR;
                  // write-only: a read header ends the frame [R21]
                  n.state = serialDataIn ? rtcs_pkg::ST_DONE : rtcs_pkg::ST_WRITE;
                end
                default: begin
                  n.state = rtcs_pkg::ST_DONE; // [R5]
                end
              endcase
            end
          end
        end
      end
      rtcs_pkg::ST_WRITE: begin
        if (sckRise) begin // [R9]
          n.dcnt = r.dcnt + 7'h1;
          case (r.cmd)
            `RTCS_CMD_STATUS: begin
              n.stShift = {serialDataIn, r.stShift[7:1]};
            end
            `RTCS_CMD_ALARM_FREQ: begin
              n.alarmReg[r.dcnt[3:0]] = serialDataIn; // [R22]
            end
            default: begin
              n.timeReg[tbit] = serialDataIn; // [R12]
            end
          endcase
          if (r.dcnt + 7'h1 == r.dlen) begin
            n.state = rtcs_pkg::ST_DONE; // [R11]
            if (r.cmd == `RTCS_CMD_STATUS) begin
              stWriteDone = 1'b1;
              n.status = ({serialDataIn, r.stShift[7:1]} & `RTCS_ST_WRITABLE) // [R14] [R17]
                | (r.status & ~`RTCS_ST_WRITABLE); // [R15]
            end
          end
        end
      end
      rtcs_pkg::ST_READ: begin
        if (sckFall) begin // [R8]
          // past the last bit the next fall frees the line
          if (r.dcnt == r.dlen) begin
            n.sdaOe = 1'b0; // [R25]
            n.state = rtcs_pkg::ST_DONE; // [R11]
          end else begin
            n.dcnt = r.dcnt + 7'h1;
            n.obit = r.obit + 3'h1;
            if (r.obit == 3'h0) begin
              n.outByte = {1'b0, popByte[7:1]};
              n.sdaOe = !popByte[0]; // [R25]
            end else begin
              n.outByte = {1'b0, r.outByte[7:1]};
              n.sdaOe = !r.outByte[0];
            end
          end
        end
      end
      rtcs_pkg::ST_DONE: begin
        n.sdaOe = 1'b0;
      end
      default: begin
        n.state = rtcs_pkg::ST_IDLE;
      end
    endcase

    // dropping chip select ends any frame and frees the line
    if (!chipSelect) begin
      n.state = rtcs_pkg::ST_IDLE;
      n.sdaOe = 1'b0; // [R25]
      n.hdr = 8'h00;
    end

    // supply-drop flag: set wins over any clear [R15]
    if (supplyLow) begin
      n.status[`RTCS_ST_POWER] = 1'b1;
    end

    // divider and per-minute timebase
    minuteCarry = 1'b0;
    if (oscTick) begin
      n.divCnt = r.divCnt + 16'h1;
      if (r.divCnt == 16'hffff) begin
        n.secCnt = (r.secCnt == `RTCS_SEC_LAST) ? 6'h00 : r.secCnt + 6'h1;
        minuteCarry = (r.secCnt == `RTCS_SEC_LAST);
      end
    end

    // interrupt mode decode
    alarmMode = r.status[`RTCS_ST_ALARM_EN] && !r.status[`RTCS_ST_MINUTE_SEL]
      && !r.status[`RTCS_ST_FREQ_SEL]; // [R28] [R18]
    freqMode = !r.status[`RTCS_ST_MINUTE_SEL] && r.status[`RTCS_ST_FREQ_SEL]; // [R19] [R20]
    edgeMode = r.status[`RTCS_ST_MINUTE_SEL] && !r.status[`RTCS_ST_FREQ_SEL]; // [R19]
    steadyMode = r.status[`RTCS_ST_MINUTE_SEL] && r.status[`RTCS_ST_FREQ_SEL]; // [R20]
    alarmMatch = (r.timeReg[`RTCS_HOUR_LSB +: 8] == r.alarmReg[7:0]) // [R23]
      && (r.timeReg[`RTCS_MINUTE_LSB +: 8] == r.alarmReg[15:8]); // [R22]
    freqLevel = (r.alarmReg != 16'h0000) && (&(r.divCnt | ~r.alarmReg)); // [R24]

    // holds: a status write clears them, an event in the same cycle wins
    if (stWriteDone) begin
      n.irqHold = 1'b0;
      n.minArmed = 1'b0;
    end
    if (alarmMode && alarmMatch) begin
      n.irqHold = 1'b1; // [R28]
    end
    if (edgeMode && minuteCarry) begin
      n.irqHold = 1'b1;
    end
    if (steadyMode && minuteCarry) begin
      n.minArmed = 1'b1;
    end

    // pin level per interrupt family
    if (alarmMode || edgeMode) begin
      n.irqOe = n.irqHold;
    end else if (freqMode) begin
      n.irqOe = freqLevel; // [R24]
    end else if (steadyMode) begin
      n.irqOe = n.minArmed && (n.secCnt < `RTCS_SEC_HALF); // [R20]
    end else begin
      n.irqOe = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.state <= rtcs_pkg::ST_IDLE;
      r.timeReg <= `RTCS_TIME_DEFAULT;
      r.status <= `RTCS_STATUS_POWERUP; // [R27]
      r.alarmReg <= `RTCS_ALARM_POWERUP; // [R27]
    end else begin
      r <= n;
    end
  end

  // status bit 6 hour format is stored only, no logic here reads it [R17]
endmodule // rtcs_serial_regs

// ### tb/rtcs_serial_regs_asserts.sv
`timescale 1ns/100ps
module rtcs_serial_regs_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chipSelect,
  input wire logic serialClock,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic oscTick,
  input wire logic irqOut,
  input wire logic irqOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic sckQ_r;
  logic [3:0] rises_r;
  // rises seen in the current frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sckQ_r <= 1'b0;
      rises_r <= 4'h0;
    end else begin
      sckQ_r <= serialClock;
      if (!chipSelect) begin
        rises_r <= 4'h0;
      end else if (serialClock && !sckQ_r && rises_r != 4'hf) begin
        rises_r <= rises_r + 4'h1;
      end
    end
  end
  sequence s_rel;
    $rose(rst_b);
  endsequence
  property p_dout_low;
    !serialDataOut && !irqOut;
  endproperty
  property p_cs_drop;
    !chipSelect |=> !serialDataOe;
  endproperty
  property p_oe_edge;
    $changed(serialDataOe) |-> !serialClock || !$past(chipSelect);
  endproperty
  property p_oe_hold;
    serialClock && $past(serialClock) |-> $stable(serialDataOe);
  endproperty
  property p_rst_quiet;
    s_rel |-> !irqOe && !serialDataOe;
  endproperty
  property p_irq_cause;
    $changed(irqOe) |-> $past(oscTick) || $past(oscTick, 2) || $past(chipSelect);
  endproperty
  property p_wait8;
    chipSelect && rises_r < 4'h8 |=> !serialDataOe;
  endproperty
  property p_oe_cs;
    serialDataOe |-> $past(chipSelect);
  endproperty
  a_dout_low: assert property (p_dout_low) else $error("output driven high");
  a_cs_drop: assert property (p_cs_drop) else $error("line held after frame");
  a_oe_edge: assert property (p_oe_edge) else $error("read bit off fall");
  a_oe_hold: assert property (p_oe_hold) else $error("read bit moved");
  a_rst_quiet: assert property (p_rst_quiet) else $error("pins busy at reset");
  a_irq_cause: assert property (p_irq_cause) else $error("irq moved alone");
  a_wait8: assert property (p_wait8) else $error("read before header");
  a_oe_cs: assert property (p_oe_cs) else $error("line driven unselected");
endmodule // rtcs_serial_regs_chk

bind rtcs_serial_regs rtcs_serial_regs_chk u_chk (.clk(clk), .rst_b(rst_b),
  .chipSelect(chipSelect), .serialClock(serialClock), .serialDataOut(serialDataOut),
  .serialDataOe(serialDataOe), .oscTick(oscTick), .irqOut(irqOut), .irqOe(irqOe));

// ### tb/rtcs_host_model.sv
`timescale 1ns/100ps
module rtcs_host_model (
  input wire logic clk,
  input wire logic dutOe,
  output logic chipSelect,
  output logic serialClock,
  output logic lineLevel
);
  logic hostOe;
  // open-drain line with pull-up
  assign lineLevel = !(hostOe || dutOe);
  initial begin
    chipSelect = 1'b0;
    serialClock = 1'b0;
    hostOe = 1'b0;
  end
  // codes 110 and 111 never sent
  task automatic xfer(input logic [7:0] hdr, input logic [55:0] wd, input int nClk,
      output logic [55:0] rd);
    rd = '0;
    @(negedge clk);
    chipSelect = 1'b1;
    for (int i = 0; i < nClk; i++) begin
      repeat (4) @(negedge clk);
      serialClock = 1'b0;
      hostOe = (i < 8) ? !hdr[7 - i] : (!hdr[0] && !wd[i - 8]);
      repeat (4) @(negedge clk);
      if (i >= 8) begin
        rd[i - 8] = lineLevel;
      end
      serialClock = 1'b1;
    end
    repeat (4) @(negedge clk);
    serialClock = 1'b0;
    hostOe = 1'b0;
    repeat (4) @(negedge clk);
    chipSelect = 1'b0;
  endtask
endmodule // rtcs_host_model

// ### tb/rtcs_serial_regs_bench.sv
`timescale 1ns/100ps
module rtcs_serial_regs_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic oscTick = 1'b0;
  logic supplyLow = 1'b0;
  logic chipSelect;
  logic serialClock;
  logic serialDataIn;
  logic serialDataOe;
  logic irqOe;
  logic [55:0] rd;
  logic [55:0] ones;
  int errors = 0;
  int checks = 0;
  always #20 clk = ~clk;
  rtcs_host_model u_host (.clk(clk), .dutOe(serialDataOe), .chipSelect(chipSelect),
    .serialClock(serialClock), .lineLevel(serialDataIn));
  rtcs_serial_regs u_dut (.clk(clk), .rst_b(rst_b), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialDataIn(serialDataIn), .serialDataOut(),
    .serialDataOe(serialDataOe), .oscTick(oscTick), .supplyLow(supplyLow), .irqOut(),
    .irqOe(irqOe));
  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmd(input logic [2:0] c, input logic r, input logic [55:0] wd, input int n);
    u_host.xfer({4'h6, c, r}, wd, 8 + n, rd);
  endtask
  task automatic tick();
    oscTick = 1'b1;
    @(negedge clk);
    oscTick = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse_supply();
    supplyLow = 1'b1;
    repeat (2) @(negedge clk);
    supplyLow = 1'b0;
  endtask
  task automatic t_powerup();
    cmd(3'h1, 1'b1, '0, 8);
    check(rd, 56'h82);
    cmd(3'h1, 1'b1, '0, 8);
    check(rd, 56'h02);
  endtask
  task automatic t_flags();
    cmd(3'h1, 1'b0, 56'hff, 12);
    cmd(3'h1, 1'b1, '0, 8);
    check(rd, 56'h6a);
    pulse_supply();
    cmd(3'h1, 1'b1, '0, 8);
    check(rd, 56'hea);
    pulse_supply();
    cmd(3'h0, 1'b1, '0, 0);
    cmd(3'h1, 1'b1, '0, 8);
    check(rd, 56'h00);
  endtask
  task automatic t_time();
    cmd(3'h0, 1'b0, '0, 0);
    cmd(3'h2, 1'b1, '0, 56);
    check(rd, 56'h00000000010100);
    cmd(3'h2, 1'b0, 56'h45301203250724, 56);
    cmd(3'h2, 1'b1, '0, 56);
    check(rd, 56'h45301203250724);
    cmd(3'h3, 1'b1, '0, 24);
    check(rd, 56'h453012);
    cmd(3'h3, 1'b0, 56'h153009, 24);
    cmd(3'h2, 1'b1, '0, 56);
    check(rd, 56'h15300903250724);
  endtask
  task automatic t_refuse();
    cmd(3'h1, 1'b0, 56'h40, 8);
    u_host.xfer(8'h72, '0, 16, rd);
    cmd(3'h5, 1'b0, '0, 16);
    u_host.xfer(8'h61, '0, 5, rd);
    cmd(3'h1, 1'b1, '0, 8);
    check(rd, 56'h40);
    cmd(3'h2, 1'b1, '0, 56);
    check(rd, 56'h15300903250724);
    cmd(3'h4, 1'b1, '0, 16);
    check(rd, 56'hffff);
  endtask
  task automatic t_freq();
    cmd(3'h1, 1'b0, 56'h02, 8);
    tick();
    tick();
    check({55'h0, irqOe}, 56'h0);
    cmd(3'h4, 1'b0, 56'h0003, 16);
    ones = '0;
    for (int k = 0; k < 8; k++) begin
      tick();
      ones = ones + {55'h0, irqOe};
    end
    check(ones, 56'h2);
  endtask
  task automatic t_alarm();
    cmd(3'h4, 1'b0, 56'h3089, 16);
    cmd(3'h1, 1'b0, 56'h20, 8);
    check({55'h0, irqOe}, 56'h0);
    cmd(3'h1, 1'b0, 56'h00, 8);
    cmd(3'h4, 1'b0, 56'h3009, 16);
    cmd(3'h1, 1'b0, 56'h20, 8);
    check({55'h0, irqOe}, 56'h1);
    cmd(3'h1, 1'b0, 56'h00, 8);
    check({55'h0, irqOe}, 56'h0);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_powerup();
    t_flags();
    t_time();
    t_refuse();
    t_freq();
    t_alarm();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule // rtcs_serial_regs_bench
